// ===== lin_flags_map.svh
// register offsets, bit positions, reset values and timing counts of the lin status flags
`ifndef LIN_FLAGS_MAP_SVH
`define LIN_FLAGS_MAP_SVH

// ======================================================================
// indirect register offsets
`define CTRL_ADDR 8'h08
`define STATUS_ADDR 8'h09
`define ERR_ADDR 8'h0a

// ======================================================================
// status bit positions
`define ST_ACTIVE 7
`define ST_IDLE 6
`define ST_ABORT 5
`define ST_DREQ 4
`define ST_INT 3
`define ST_ERROR 2
`define ST_WAKEUP 1
`define ST_DONE 0

// ======================================================================
// control bit positions
`define CT_STOP 7
`define CT_SLEEP 6
`define CT_TXRX 5
`define CT_DTACK 4
`define CT_INTERRUPT_RESET_CONTROL 3
`define CT_ERROR_RESET_CONTROL 2
`define CT_WUPREQ 1
`define CT_STREQ 0

// ======================================================================
// reset values
`define STATUS_RESET 8'h00
`define CTRL_RESET 8'h00
`define ERR_RESET 5'h00

// ======================================================================
// timing
`define CLK_HZ 25000000
`define IDLE_TIMEOUT_S 4
`define IDLE_CYCLES (`IDLE_TIMEOUT_S * `CLK_HZ)

`endif

// ===== lin_flags_pkg.sv
// types shared by the lin status flag logic
package lin_flags_pkg;

  typedef logic [7:0] reg8_t;

  // error detail layout: sync, parity, timeout, checksum, bit error
  typedef logic [4:0] err_vec_t;

  // which register an access selects
  typedef enum logic [3:0] {
    SEL_NONE = 4'h1,
    SEL_CTRL = 4'h2,
    SEL_STATUS = 4'h4,
    SEL_ERR = 4'h8
  } reg_sel_t;

endpackage : lin_flags_pkg

// ===== idle_timer.sv
// bus idle timer: counts cycles while armed and flags expiry
module idle_timer #(
  parameter int unsigned CYCLES = 100000000
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic run,
  output logic expired
);

  localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;

  generate
    if (CYCLES < 1) begin : g_bad_cycles
      $error("idle_timer: CYCLES must be at least 1");
    end
  endgenerate

  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic expired_q;
  logic expired_d;
  wire at_last = (cnt_q == LAST);

  // count restarts whenever the idle condition breaks
  assign cnt_d = !run ? '0 : (at_last ? cnt_q : cnt_q + W'(1));
  assign expired_d = run && (expired_q || at_last);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_q <= '0;
      expired_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      expired_q <= expired_d;
    end
  end

  assign expired = expired_q;

endmodule : idle_timer

// ===== lin_status_flags.sv
// status flag register bank of a lin master/slave controller
`include "lin_flags_map.svh"

module lin_status_flags
  import lin_flags_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES = `IDLE_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // frame engine events and levels
  input wire logic slave_mode,
  input wire logic bus_activity,
  input wire logic bus_asleep,
  input wire logic sync_break,
  input wire logic xfer_pending,
  input wire logic data_id_rx,
  input wire logic xfer_start,
  input wire logic xfer_done,
  input wire logic wakeup_tx,
  input wire logic wakeup_rx,
  input wire logic [4:0] err_event,
  // control towards the frame engine
  output logic stop_req,
  output logic data_ack,
  output logic int_reset,
  output logic err_reset,
  output logic sleep_en,
  output logic tx_mode,
  output logic wakeup_req,
  output logic start_req,
  // flag levels
  output logic [7:0] lin_status,
  output logic [4:0] error_detail_reg,
  output logic irq
);

  generate
    if (IDLE_CYCLES < 1) begin : g_bad_idle
      $error("lin_status_flags: IDLE_CYCLES must be at least 1");
    end
  endgenerate

  // ======================================================================
  // address decode

  function automatic reg_sel_t decode(input logic [7:0] a);
    case (a)
      `CTRL_ADDR: decode = SEL_CTRL;
      `STATUS_ADDR: decode = SEL_STATUS;
      `ERR_ADDR: decode = SEL_ERR;
      default: decode = SEL_NONE;
    endcase
  endfunction : decode

  reg_sel_t wr_sel;
  reg_sel_t rd_sel;
  assign wr_sel = decode(addr);
  assign rd_sel = decode(addr);

  wire ctrl_wr = wr && (wr_sel == SEL_CTRL);

  // write-one command bits; writing zero has no effect
  wire cmd_stop = ctrl_wr && wdata[`CT_STOP];
  wire cmd_interrupt_reset_control = ctrl_wr && wdata[`CT_INTERRUPT_RESET_CONTROL];
  wire cmd_error_reset_control = ctrl_wr && wdata[`CT_ERROR_RESET_CONTROL];
  wire cmd_dtack = ctrl_wr && wdata[`CT_DTACK];
  wire cmd_wupreq = ctrl_wr && wdata[`CT_WUPREQ];
  wire cmd_streq = ctrl_wr && wdata[`CT_STREQ];

  // ======================================================================
  // control register: only sleep, txrx, dtack, wupreq, streq are stored

  logic sleep_q;
  logic sleep_d;
  logic txrx_q;
  logic txrx_d;
  logic dtack_q;
  logic dtack_d;
  logic wupreq_q;
  logic wupreq_d;
  logic streq_q;
  logic streq_d;

  assign sleep_d = ctrl_wr ? wdata[`CT_SLEEP] : sleep_q;
  assign txrx_d = ctrl_wr ? wdata[`CT_TXRX] : txrx_q;
  // acknowledge lasts one cycle, the controller drops it itself
  assign dtack_d = cmd_dtack;
  // wakeup request held until the wakeup signal goes out
  assign wupreq_d = cmd_wupreq || (wupreq_q && !wakeup_tx);
  // start request dropped on completion or error
  wire any_err = |err_event;
  assign streq_d = cmd_streq || (streq_q && !xfer_done && !any_err);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sleep_q <= 1'b0;
      txrx_q <= 1'b0;
      dtack_q <= 1'b0;
      wupreq_q <= 1'b0;
      streq_q <= 1'b0;
    end else begin
      sleep_q <= sleep_d;
      txrx_q <= txrx_d;
      dtack_q <= dtack_d;
      wupreq_q <= wupreq_d;
      streq_q <= streq_d;
    end
  end

  // ======================================================================
  // bus activity and idle timeout

  logic active_q;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      active_q <= 1'b0;
    end else begin
      active_q <= bus_activity;
    end
  end

  wire idle_run = slave_mode && !bus_activity && !bus_asleep;
  logic idle_expired;

  idle_timer #(
    .CYCLES(IDLE_CYCLES)
  ) u_idle_timer (
    .mclk(mclk),
    .rstn(rstn),
    .run(idle_run),
    .expired(idle_expired)
  );

  // ======================================================================
  // abort flag

  logic abort_q;
  logic abort_d;
  wire abort_set = slave_mode && ((sync_break && xfer_pending) || cmd_stop);
  wire abort_clr = sync_break && !xfer_pending;
  assign abort_d = abort_set || (abort_q && !abort_clr && slave_mode);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      abort_q <= 1'b0;
    end else begin
      abort_q <= abort_d;
    end
  end

  // ======================================================================
  // data request flag: cleared by acknowledge or a new frame

  logic dreq_q;
  logic dreq_d;
  wire dreq_clr = cmd_dtack || sync_break;
  assign dreq_d = slave_mode && (data_id_rx || (dreq_q && !dreq_clr));

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      dreq_q <= 1'b0;
    end else begin
      dreq_q <= dreq_d;
    end
  end

  // ======================================================================
  // wakeup flag: transmitting level or received memory

  logic wake_rx_q;
  logic wake_rx_d;
  assign wake_rx_d = wakeup_rx || (wake_rx_q && !sync_break);
  wire wake_flag = wakeup_tx || wake_rx_q;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wake_rx_q <= 1'b0;
    end else begin
      wake_rx_q <= wake_rx_d;
    end
  end

  // ======================================================================
  // completion flag; done wins over a start in the same cycle

  logic done_q;
  logic done_d;
  assign done_d = xfer_done || (done_q && !xfer_start);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end

  // ======================================================================
  // error flag and error detail; event wins over the reset command

  logic error_q;
  logic error_d;
  err_vec_t err_det_q;
  err_vec_t err_det_d;
  assign error_d = any_err || (error_q && !cmd_error_reset_control);
  assign err_det_d = err_event | (cmd_error_reset_control ? `ERR_RESET : err_det_q);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      error_q <= 1'b0;
      err_det_q <= `ERR_RESET;
    end else begin
      error_q <= error_d;
      err_det_q <= err_det_d;
    end
  end

  // ======================================================================
  // interrupt pending flag

  logic int_q;
  logic int_d;
  wire int_cause = xfer_done || (slave_mode && data_id_rx) || wakeup_rx || any_err;
  assign int_d = int_cause || (int_q && !cmd_interrupt_reset_control);
  // flag raised together with the cause flag on the same edge
  wire int_now = int_q;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      int_q <= 1'b0;
    end else begin
      int_q <= int_d;
    end
  end

  // ======================================================================
  // status assembly

  reg8_t status_w;
  assign status_w[`ST_ACTIVE] = active_q;
  assign status_w[`ST_IDLE] = idle_expired;
  assign status_w[`ST_ABORT] = abort_q;
  assign status_w[`ST_DREQ] = dreq_q;
  assign status_w[`ST_INT] = int_now;
  assign status_w[`ST_ERROR] = error_q;
  assign status_w[`ST_WAKEUP] = wake_flag;
  assign status_w[`ST_DONE] = done_q;

  // ======================================================================
  // read path: stop and both reset command bits always read zero

  reg8_t ctrl_rd;
  assign ctrl_rd = {1'b0, sleep_q, txrx_q, dtack_q, 1'b0, 1'b0, wupreq_q, streq_q};

  reg8_t rd_mux;
  assign rd_mux = (rd_sel == SEL_CTRL) ? ctrl_rd :
                  (rd_sel == SEL_STATUS) ? status_w :
                  (rd_sel == SEL_ERR) ? {3'h0, err_det_q} :
                  8'h00;

  reg8_t rdata_q;
  reg8_t rdata_d;
  // data stand only in the cycle after the strobe
  assign rdata_d = rd ? rd_mux : 8'h00;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ======================================================================
  // outputs

  assign rdata = rdata_q;
  assign stop_req = cmd_stop;
  assign data_ack = dtack_q;
  assign int_reset = cmd_interrupt_reset_control;
  assign err_reset = cmd_error_reset_control;
  assign sleep_en = sleep_q;
  assign tx_mode = txrx_q;
  assign wakeup_req = wupreq_q;
  assign start_req = streq_q;
  assign lin_status = status_w;
  assign error_detail_reg = err_det_q;
  assign irq = int_q;

endmodule : lin_status_flags

// ===== lin_status_flags_props.sv
// assertions on the ports of the lin status flags
module lin_status_flags_props (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic slave_mode,
  input wire logic bus_activity,
  input wire logic sync_break,
  input wire logic xfer_pending,
  input wire logic xfer_start,
  input wire logic xfer_done,
  input wire logic wakeup_tx,
  input wire logic [4:0] err_event,
  input wire logic [7:0] lin_status,
  input wire logic [4:0] error_detail_reg,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  wire ctl_wr = wr && addr == 8'h08;
  // ==========
  // control writes
  sequence s_stop;
    slave_mode && ctl_wr && wdata[7];
  endsequence
  sequence s_err_clear;
    ctl_wr && wdata[2] && err_event == 5'h00;
  endsequence
  // ==========
  // flags
  AST_ACTIVE: assert property (1 |=> lin_status[7] == $past(bus_activity))
    else $error("activity flag wrong");
  AST_ABORT_SET: assert property (slave_mode && sync_break && xfer_pending |=> lin_status[5])
    else $error("abort not set by break");
  AST_STOP: assert property (s_stop |=> lin_status[5])
    else $error("abort not set by stop");
  AST_ABORT_CLR: assert property (sync_break && !xfer_pending && !ctl_wr |=> !lin_status[5])
    else $error("abort not cleared");
  AST_INT_HOLD: assert property (lin_status[3] && !(ctl_wr && wdata[3]) |=> lin_status[3])
    else $error("interrupt flag lost");
  AST_ERR_HOLD: assert property (lin_status[2] && !(ctl_wr && wdata[2]) |=> lin_status[2])
    else $error("error flag lost");
  AST_ERR_CLR: assert property (s_err_clear |=> !lin_status[2] && error_detail_reg == 5'h00)
    else $error("error clear failed");
  AST_WAKE: assert property (wakeup_tx |-> lin_status[1])
    else $error("wakeup flag low while sending");
  AST_DONE_SET: assert property (xfer_done |=> lin_status[0])
    else $error("done not set");
  AST_DONE_CLR: assert property (xfer_start && !xfer_done |=> !lin_status[0])
    else $error("done not cleared");
  AST_INT_CAUSE: assert property (xfer_done || err_event != 5'h00 |=> lin_status[3] && irq)
    else $error("interrupt late");
endmodule : lin_status_flags_props

// ===== lin_node_model.sv
// bus node model: frames of break, identifier, data and completion
module lin_node_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic go,
  input wire logic [3:0] len,
  output logic bus_activity,
  output logic sync_break,
  output logic xfer_pending,
  output logic data_id_rx,
  output logic xfer_start,
  output logic xfer_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] left_q;
  // a break opens each frame, also one that cuts into the last
  assign sync_break = go;
  assign xfer_start = go;
  assign xfer_pending = left_q != 4'h0;
  assign bus_activity = xfer_pending;
  assign data_id_rx = left_q == 4'h2;
  assign xfer_done = left_q == 4'h1;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      left_q <= 4'h0;
    end else if (go) begin
      left_q <= len;
    end else if (xfer_pending) begin
      left_q <= left_q - 4'h1;
    end
  end
endmodule : lin_node_model

// ===== lin_status_flags_bench.sv
// testbench of the lin status flags beside a bus node model
module lin_status_flags_bench;
  import lin_flags_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rstn = 0, wr = 0, rd = 0, slave_mode = 0, bus_asleep = 1;
  logic wakeup_tx = 0, wakeup_rx = 0, go = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic [3:0] len = 4'h3;
  logic [4:0] err_event = 5'h00, e;
  wire logic [7:0] rdata, lin_status;
  wire logic [4:0] error_detail_reg;
  wire logic bus_activity, sync_break, xfer_pending, data_id_rx, xfer_start, xfer_done, irq;
  wire logic stop_req, data_ack, int_reset, err_reset, sleep_en, tx_mode, wakeup_req, start_req;
  int err_count = 0, compares = 0;
  reg8_t v;
  always #20 mclk = ~mclk;
  lin_node_model u_lin_node_model (.mclk, .rstn, .go, .len, .bus_activity, .sync_break,
    .xfer_pending, .data_id_rx, .xfer_start, .xfer_done);
  lin_status_flags #(.IDLE_CYCLES(20)) u_lin_status_flags (.mclk, .rstn, .addr, .wdata,
    .wr, .rd, .rdata, .slave_mode, .bus_activity, .bus_asleep, .sync_break, .xfer_pending,
    .data_id_rx, .xfer_start, .xfer_done, .wakeup_tx, .wakeup_rx, .err_event, .stop_req,
    .data_ack, .int_reset, .err_reset, .sleep_en, .tx_mode, .wakeup_req,
    .start_req, .lin_status, .error_detail_reg, .irq);
  // ==========
  // tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic frame(input logic [3:0] n);
    @(posedge mclk);
    go <= 1'b1;
    len <= n;
    @(posedge mclk);
    go <= 1'b0;
    #1;
  endtask : frame
  task automatic conclude();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  // ==========
  // tests
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    conclude();
  end
  initial begin
    void'($urandom(86));
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    rd_reg(8'h09);
    check(v, 8'h00);
    wr_reg(8'h09, 8'hff);
    rd_reg(8'h09);
    check(v, 8'h00);
    rd_reg(8'h5c);
    check(v, 8'h00);
    $display("end registers");
    @(posedge mclk);
    slave_mode <= 1'b1;
    frame(4'($urandom_range(3, 9)));
    for (int i = 0; i < 20 && lin_status[0] !== 1'b1; i++) settle(1);
    rd_reg(8'h09);
    check(v, 8'h19);
    wr_reg(8'h08, 8'h08);
    rd_reg(8'h09);
    check(v, 8'h11);
    rd_reg(8'h08);
    check(v, 8'h00);
    frame(4'h9);
    settle(1);
    check(lin_status & 8'h81, 8'h80);
    frame(4'h5);
    check(lin_status & 8'h20, 8'h20);
    settle(7);
    frame(4'h3);
    check(lin_status & 8'h20, 8'h00);
    wr_reg(8'h08, 8'h80);
    rd_reg(8'h09);
    check(v & 8'h20, 8'h20);
    $display("end frames");
    for (int i = 0; i < 6; i++) begin
      e = (i < 5) ? 5'h01 << i : 5'($urandom_range(1, 31));
      @(posedge mclk);
      err_event <= e;
      @(posedge mclk);
      err_event <= 5'h00;
      rd_reg(8'h0a);
      check(v, {3'h0, e});
      check({3'h0, error_detail_reg}, {3'h0, e});
      rd_reg(8'h09);
      check(v & 8'h0c, 8'h0c);
      wr_reg(8'h08, 8'h0c);
      rd_reg(8'h0a);
      check(v, 8'h00);
      rd_reg(8'h09);
      check(v & 8'h0c, 8'h00);
    end
    $display("end errors");
    @(posedge mclk);
    wakeup_tx <= 1'b1;
    settle(1);
    check(lin_status & 8'h02, 8'h02);
    @(posedge mclk);
    wakeup_tx <= 1'b0;
    wakeup_rx <= 1'b1;
    @(posedge mclk);
    wakeup_rx <= 1'b0;
    rd_reg(8'h09);
    check(v & 8'h0a, 8'h0a);
    check({7'h0, irq}, 8'h01);
    $display("end wakeup");
    wr_reg(8'h08, 8'h73);
    #1 check({3'h0, sleep_en, tx_mode, data_ack, wakeup_req, start_req}, 8'h1f);
    rd_reg(8'h08);
    check(v, 8'h63);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= 8'h08;
    wdata <= 8'h8c;
    #1 check({5'h0, stop_req, int_reset, err_reset}, 8'h07);
    @(posedge mclk);
    wr <= 1'b0;
    #1 check(lin_status & 8'h2c, 8'h20);
    $display("end control");
    @(posedge mclk);
    bus_asleep <= 1'b0;
    settle(19);
    check(lin_status & 8'h40, 8'h00);
    settle(1);
    check(lin_status & 8'h40, 8'h40);
    @(posedge mclk);
    bus_asleep <= 1'b1;
    settle(2);
    check(lin_status & 8'h40, 8'h00);
    @(posedge mclk);
    slave_mode <= 1'b0;
    bus_asleep <= 1'b0;
    settle(25);
    check(lin_status & 8'h40, 8'h00);
    $display("end idle");
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rd_reg(8'h09);
    check(v, 8'h00);
    check({3'h0, sleep_en, tx_mode, data_ack, wakeup_req, start_req}, 8'h00);
    $display("end reset");
    conclude();
  end
endmodule : lin_status_flags_bench

bind lin_status_flags lin_status_flags_props u_lin_status_flags_props (.mclk, .rstn, .addr,
  .wdata, .wr, .slave_mode, .bus_activity, .sync_break, .xfer_pending, .xfer_start,
  .xfer_done, .wakeup_tx, .err_event, .lin_status, .error_detail_reg, .irq);
